// ==== rtl/acsr_buf2.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides on the same clock; storage in flip-flops.
`timescale 1ns/1ps
module acsr_buf2 #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data = mem_q[rd_ptr_q];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push) begin
				mem_q[wr_ptr_q] <= in_data;
				wr_ptr_q <= !wr_ptr_q;
			end
			if (pop)
				rd_ptr_q <= !rd_ptr_q;
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// ==== rtl/acsr_pkg.sv ====
// Shared constants and carrier types of the converter control block.
// Assumes one 50 MHz system clock and pin inputs that are not yet synchronised.
package acsr_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int CONV_TIME_NS = 4000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_PERIOD_NS = 200;
	localparam int SCLK_CYCLES = SCLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SCLK_HIGH_AT = SCLK_CYCLES / 2;
	localparam int DATA_CHANGE_AT = SCLK_HIGH_AT / 2;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int BIT_CNT_W = 5;
	localparam int CONV_CNT_W = 8;
	localparam int PHASE_W = 4;
	localparam logic [BIT_CNT_W-1:0] BITS_PER_WORD = 5'h10;
	localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
	localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(SCLK_CYCLES - 1);
	localparam logic [PHASE_W-1:0] PHASE_HIGH = PHASE_W'(SCLK_HIGH_AT);
	localparam logic [PHASE_W-1:0] PHASE_CHANGE = PHASE_W'(DATA_CHANGE_AT);
	localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Channel codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CHAN_ONE = 2'h0;
	localparam logic [1:0] CHAN_TWO = 2'h1;
	localparam logic [1:0] CHAN_THREE = 2'h2;
	localparam logic [1:0] CHAN_FOUR = 2'h3;
	localparam logic [1:0] CHAN_RESET = CHAN_ONE;

	// ----------------------------------------------------------------
	// States and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_PUSH} acsr_conv_e;
	typedef enum logic [1:0] {SH_IDLE, SH_INT, SH_EXT_WAIT, SH_EXT} acsr_shift_e;

	typedef struct packed {
		logic cs_n;
		logic rd_conv;
		logic power_down;
		logic clk_sel;
		logic sclk;
		logic strobe_a_n;
		logic strobe_b_n;
		logic [1:0] addr;
	} acsr_pins_s;

	localparam acsr_pins_s PINS_RESET = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0};

endpackage

// ==== rtl/acsr_top.sv ====
// Conversion control, channel latch and serial readout of a four-channel converter.
// Assumes an analog core that presents its result on adc_result at the end of conversion,
// and host pins from outside the clock domain.
`timescale 1ns/1ps

module acsr_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic rd_conv,
	input wire logic power_down_input,
	input wire logic clock_source_select,
	input wire logic serial_bit_clock_i,
	output logic serial_bit_clock_o,
	output logic serial_bit_clock_oe,
	input wire logic mux_latch_strobe_a_n,
	input wire logic mux_latch_strobe_b_n,
	input wire logic channel_addr_hi,
	input wire logic channel_addr_lo,
	input wire logic [15:0] adc_result,
	output logic busy_n,
	output logic serial_data,
	output logic frame_sync,
	output logic [1:0] channel_select,
	output logic sample_hold,
	output logic power_save
);

	// ----------------------------------------------------------------
	// Edge helpers
	// ----------------------------------------------------------------
	function automatic logic fell(input logic prev, input logic cur);
		fell = prev && !cur;
	endfunction

	function automatic logic rose(input logic prev, input logic cur);
		rose = !prev && cur;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	acsr_pkg::acsr_pins_s pins_raw;
	acsr_pkg::acsr_pins_s meta_q;
	acsr_pkg::acsr_pins_s pins_q;
	acsr_pkg::acsr_pins_s prev_q;

	assign pins_raw = '{cs_n, rd_conv, power_down_input, clock_source_select,
		serial_bit_clock_i, mux_latch_strobe_a_n, mux_latch_strobe_b_n,
		{channel_addr_hi, channel_addr_lo}};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= acsr_pkg::PINS_RESET;
			pins_q <= acsr_pkg::PINS_RESET;
			prev_q <= acsr_pkg::PINS_RESET;
		end else begin
			meta_q <= pins_raw;
			pins_q <= meta_q;
			prev_q <= pins_q;
		end
	end

	// ----------------------------------------------------------------
	// Host event decode
	// ----------------------------------------------------------------
	wire ctl_now = pins_q.cs_n | pins_q.rd_conv;
	wire ctl_prev = prev_q.cs_n | prev_q.rd_conv;
	wire cs_fell = fell(prev_q.cs_n, pins_q.cs_n);
	wire rc_rose = rose(prev_q.rd_conv, pins_q.rd_conv);
	wire ext_mode = pins_q.clk_sel;
	wire sclk_rose = rose(prev_q.sclk, pins_q.sclk);
	wire sclk_fell = fell(prev_q.sclk, pins_q.sclk);

	// Conversion request from either control falling with the other low
	wire conv_req = fell(ctl_prev, ctl_now);
	wire conv_go = conv_req && !pins_q.power_down;
	wire read_by_cs = cs_fell && pins_q.rd_conv;
	wire read_by_rc = rc_rose && !pins_q.cs_n;
	wire read_req = (read_by_cs || read_by_rc) && ext_mode;

	// ----------------------------------------------------------------
	// Channel address latch
	// ----------------------------------------------------------------
	wire latch_en_n = pins_q.strobe_a_n | pins_q.strobe_b_n;
	logic [1:0] chan_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			chan_q <= acsr_pkg::CHAN_RESET;
		else if (!latch_en_n)
			chan_q <= pins_q.addr;
	end

	// Code picks input: 0 one, 1 two, 2 three, 3 four
	assign channel_select = chan_q;

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	acsr_pkg::acsr_conv_e cv_q;
	logic [acsr_pkg::CONV_CNT_W-1:0] conv_cnt_q;
	logic [1:0] conv_chan_q;
	logic sample_q;
	logic power_q;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [acsr_pkg::DATA_W-1:0] buf_out_data;
	wire conv_done = (cv_q == acsr_pkg::CV_RUN) && (conv_cnt_q == acsr_pkg::CONV_LAST);
	wire push_now = (cv_q == acsr_pkg::CV_PUSH) && buf_in_ready;
	wire cv_start = (cv_q == acsr_pkg::CV_IDLE) && conv_go;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cv_q <= acsr_pkg::CV_IDLE;
			conv_cnt_q <= '0;
			conv_chan_q <= acsr_pkg::CHAN_RESET;
			sample_q <= 1'b0;
		end else begin
			case (cv_q)
				acsr_pkg::CV_IDLE: begin
					if (cv_start) begin
						cv_q <= acsr_pkg::CV_RUN;
						conv_cnt_q <= '0;
						conv_chan_q <= chan_q;
						sample_q <= 1'b1;
					end
				end
				acsr_pkg::CV_RUN: begin
					conv_cnt_q <= conv_cnt_q + 1'b1;
					if (conv_done)
						cv_q <= acsr_pkg::CV_PUSH;
				end
				acsr_pkg::CV_PUSH: begin
					if (buf_in_ready) begin
						cv_q <= acsr_pkg::CV_IDLE;
						sample_q <= 1'b0;
					end
				end
				default: begin
					cv_q <= acsr_pkg::CV_IDLE;
					sample_q <= 1'b0;
				end
			endcase
		end
	end

	assign sample_hold = sample_q;

	// Reduced consumption follows the power-down pin
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			power_q <= 1'b0;
		else
			power_q <= pins_q.power_down;
	end

	assign power_save = power_q;

	// ----------------------------------------------------------------
	// Result buffer between converter and shifter
	// ----------------------------------------------------------------
	logic buf_pop;

	acsr_buf2 #(
		.W(acsr_pkg::DATA_W)
	) u_buf (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(cv_q == acsr_pkg::CV_PUSH),
		.in_ready(buf_in_ready),
		.in_data(adc_result),
		.out_valid(buf_out_valid),
		.out_ready(buf_pop),
		.out_data(buf_out_data)
	);

	// ----------------------------------------------------------------
	// Serial shifter
	// ----------------------------------------------------------------
	acsr_pkg::acsr_shift_e sh_q;
	logic [acsr_pkg::DATA_W-1:0] shreg_q;
	logic [acsr_pkg::BIT_CNT_W-1:0] bits_q;
	logic [acsr_pkg::PHASE_W-1:0] phase_q;
	logic data_q;
	logic sclk_q;
	logic sync_q;
	logic busy_n_q;

	wire sh_idle = (sh_q == acsr_pkg::SH_IDLE);
	// New result enters the shifter only between readouts
	assign buf_pop = sh_idle && buf_out_valid && !cv_start;
	wire int_go = cv_start && !ext_mode;
	wire phase_end = (phase_q == acsr_pkg::PHASE_LAST);
	wire int_change = (phase_q == acsr_pkg::PHASE_CHANGE);
	wire last_bit = (bits_q == acsr_pkg::BITS_PER_WORD - 1'b1);
	wire ext_done = (bits_q == acsr_pkg::BITS_PER_WORD);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sh_q <= acsr_pkg::SH_IDLE;
			shreg_q <= acsr_pkg::RESULT_RESET;
			bits_q <= '0;
			phase_q <= '0;
			data_q <= 1'b0;
			sclk_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			case (sh_q)
				acsr_pkg::SH_IDLE: begin
					sclk_q <= 1'b0;
					sync_q <= 1'b0;
					bits_q <= '0;
					phase_q <= '0;
					if (buf_pop)
						shreg_q <= buf_out_data;
					if (int_go)
						sh_q <= acsr_pkg::SH_INT;
					else if (read_req)
						sh_q <= acsr_pkg::SH_EXT_WAIT;
				end
				acsr_pkg::SH_INT: begin
					phase_q <= phase_end ? '0 : phase_q + 1'b1;
					sclk_q <= (phase_q >= acsr_pkg::PHASE_HIGH - 1'b1) && !phase_end;
					if (int_change) begin
						data_q <= shreg_q[acsr_pkg::DATA_W-1];
						shreg_q <= {shreg_q[acsr_pkg::DATA_W-2:0], shreg_q[acsr_pkg::DATA_W-1]};
					end
					if (phase_end) begin
						bits_q <= bits_q + 1'b1;
						if (last_bit)
							sh_q <= acsr_pkg::SH_IDLE;
					end
				end
				acsr_pkg::SH_EXT_WAIT: begin
					if (!ext_mode) begin
						sh_q <= acsr_pkg::SH_IDLE;
					end else if (sclk_fell) begin
						sync_q <= 1'b1;
						data_q <= shreg_q[acsr_pkg::DATA_W-1];
						shreg_q <= {shreg_q[acsr_pkg::DATA_W-2:0], shreg_q[acsr_pkg::DATA_W-1]};
						bits_q <= 5'h01;
						sh_q <= acsr_pkg::SH_EXT;
					end
				end
				acsr_pkg::SH_EXT: begin
					if (!ext_mode) begin
						sh_q <= acsr_pkg::SH_IDLE;
					end else if (sclk_fell) begin
						sync_q <= 1'b0;
						if (ext_done) begin
							sh_q <= acsr_pkg::SH_IDLE;
						end else begin
							data_q <= shreg_q[acsr_pkg::DATA_W-1];
							shreg_q <= {shreg_q[acsr_pkg::DATA_W-2:0],
								shreg_q[acsr_pkg::DATA_W-1]};
							bits_q <= bits_q + 1'b1;
						end
					end
				end
				default: begin
					sh_q <= acsr_pkg::SH_IDLE;
					sclk_q <= 1'b0;
					sync_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Busy and pin drivers
	// ----------------------------------------------------------------
	// Busy falls at start, rises once the result reaches the shifter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			busy_n_q <= 1'b1;
		else if (cv_start)
			busy_n_q <= 1'b0;
		else if (buf_pop && cv_q == acsr_pkg::CV_IDLE && !push_now)
			busy_n_q <= 1'b1;
	end

	logic sclk_oe_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sclk_oe_q <= 1'b1;
		else
			sclk_oe_q <= !ext_mode;
	end

	assign busy_n = busy_n_q;
	assign serial_data = data_q;
	assign frame_sync = sync_q;
	assign serial_bit_clock_o = sclk_q;
	assign serial_bit_clock_oe = sclk_oe_q;

endmodule

// ==== test/acsr_host_model.sv ====
// Host serial port model: external bit clock and receiver.
// Assumes the bench starts one frame at a time with go.
`timescale 1ns/1ps
module acsr_host_model (
	input wire logic go,
	input wire logic serial_data,
	output logic sclk,
	output logic [15:0] word,
	output logic done
);
	// ----------------------------------------------------------------
	// Frame of 17 periods, clock idle low between frames
	// ----------------------------------------------------------------
	initial begin
		sclk = 1'b0;
		word = 16'h0000;
		done = 1'b0;
	end
	always @(posedge go) begin
		done = 1'b0;
		repeat (17) begin
			#80 sclk = 1'b1;
			word = {word[14:0], serial_data};
			#80 sclk = 1'b0;
		end
		done = 1'b1;
	end
endmodule

// ==== test/acsr_top_sva.sv ====
// Assertion checker for the converter control top.
// Assumes one clock domain and the package timing constants.
`timescale 1ns/1ps
module acsr_top_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic mux_latch_strobe_a_n,
	input wire logic mux_latch_strobe_b_n,
	input wire logic channel_addr_hi,
	input wire logic channel_addr_lo,
	input wire logic busy_n,
	input wire logic serial_data,
	input wire logic serial_bit_clock_o,
	input wire logic serial_bit_clock_oe,
	input wire logic frame_sync,
	input wire logic [1:0] channel_select,
	input wire logic sample_hold,
	input wire logic power_save
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ----------------------------------------------------------------
	// Busy length counter
	// ----------------------------------------------------------------
	logic [9:0] low_cnt_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt_q <= 10'h000;
		end else if (busy_n) begin
			low_cnt_q <= 10'h000;
		end else if (low_cnt_q != 10'h3FF) begin
			low_cnt_q <= low_cnt_q + 10'h001;
		end
	end
	a_busy_min_len: assert property ($rose(busy_n) |-> $past(low_cnt_q) >= 10'h0C7)
		else $error("busy low too short");
	a_busy_max_len: assert property (low_cnt_q < 10'h190)
		else $error("busy low too long");
	a_hold_at_start: assert property ($fell(busy_n) |-> sample_hold)
		else $error("input not held at start");
	a_pd_no_start: assert property (power_save && $past(power_save) && $past(power_save, 2)
		|-> !$fell(busy_n))
		else $error("conversion started in power-down");
	a_clk_pin_dir: assert property (serial_bit_clock_o |-> serial_bit_clock_oe)
		else $error("bit clock driven while input");
	a_clk_high_len: assert property ($rose(serial_bit_clock_o) |->
		serial_bit_clock_o[*5] ##1 !serial_bit_clock_o)
		else $error("bit clock high phase wrong");
	a_clk_low_len: assert property ($fell(serial_bit_clock_o) |-> !serial_bit_clock_o[*5])
		else $error("bit clock low phase short");
	a_bit_stable: assert property ((serial_bit_clock_o || $fell(serial_bit_clock_o))
		|-> $stable(serial_data))
		else $error("data moved around clock edge");
	a_sync_ext: assert property (frame_sync |-> !serial_bit_clock_oe)
		else $error("frame pulse in internal mode");
	a_sync_width: assert property ($rose(frame_sync) |-> frame_sync[*6] ##[1:4] !frame_sync)
		else $error("frame pulse width wrong");
	a_latch_follow: assert property ((!mux_latch_strobe_a_n && !mux_latch_strobe_b_n
		&& $stable({channel_addr_hi, channel_addr_lo}))[*5]
		|-> channel_select == {channel_addr_hi, channel_addr_lo})
		else $error("latch not transparent");
	a_latch_hold: assert property ((mux_latch_strobe_a_n || mux_latch_strobe_b_n)[*5]
		|-> $stable(channel_select))
		else $error("latch not holding");
endmodule
bind acsr_top acsr_top_sva chk_u (.clk, .reset_n, .mux_latch_strobe_a_n,
	.mux_latch_strobe_b_n, .channel_addr_hi, .channel_addr_lo, .busy_n, .serial_data,
	.serial_bit_clock_o, .serial_bit_clock_oe, .frame_sync, .channel_select, .sample_hold,
	.power_save);

// ==== test/tb_top.sv ====
// Self-checking bench for the converter control top.
// Assumes the host model file and the bound checker.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic cs_n = 1'b1;
	logic rd_conv = 1'b1;
	logic pd = 1'b0;
	logic ext_sel = 1'b0;
	logic str_a_n = 1'b0;
	logic str_b_n = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [15:0] adc = 16'h0000;
	logic host_go = 1'b0;
	logic fs_seen = 1'b0;
	logic [15:0] int_word = 16'h0000;
	logic host_sclk, host_done, sclk_pin, sclk_o, sclk_oe;
	logic busy_n, sdata, fsync, shold, psave;
	logic [1:0] chan;
	logic [15:0] host_word;
	int int_cnt, fail_count, cmp_count;
	always #10 clk = ~clk;
	assign sclk_pin = sclk_oe ? sclk_o : host_sclk;
	acsr_top dut_u (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .rd_conv(rd_conv),
		.power_down_input(pd), .clock_source_select(ext_sel), .serial_bit_clock_i(sclk_pin),
		.serial_bit_clock_o(sclk_o), .serial_bit_clock_oe(sclk_oe),
		.mux_latch_strobe_a_n(str_a_n), .mux_latch_strobe_b_n(str_b_n),
		.channel_addr_hi(addr[1]), .channel_addr_lo(addr[0]), .adc_result(adc),
		.busy_n(busy_n), .serial_data(sdata), .frame_sync(fsync), .channel_select(chan),
		.sample_hold(shold), .power_save(psave));
	acsr_host_model host_u (.go(host_go), .serial_data(sdata), .sclk(host_sclk),
		.word(host_word), .done(host_done));
	always @(posedge sclk_o) begin
		if (sclk_oe === 1'b1) begin
			int_word = {int_word[14:0], sdata};
			int_cnt++;
		end
	end
	always @(posedge clk) begin
		if (fsync === 1'b1) begin
			fs_seen <= 1'b1;
		end
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy_n !== lvl && n < 500) begin
			step(1);
			n++;
		end
		check("busy_n", busy_n, lvl);
	endtask
	task automatic convert(input logic [15:0] val);
		adc = val;
		cs_n = 1'b1;
		rd_conv = 1'b0;
		step(4);
		cs_n = 1'b0;
		wait_busy(1'b0);
		check("sample_hold", shold, 1'b1);
	endtask
	task automatic finish_conv();
		cs_n = 1'b1;
		step(4);
		rd_conv = 1'b1;
		wait_busy(1'b1);
	endtask
	task automatic host_read(input logic [15:0] exp);
		fs_seen = 1'b0;
		host_go = 1'b1;
		@(posedge host_done);
		step(10);
		host_go = 1'b0;
		check("ext word", host_word, exp);
		check("frame_sync", fs_seen, 1'b1);
	endtask
	task automatic read_after(input logic [15:0] exp);
		cs_n = 1'b1;
		rd_conv = 1'b1;
		step(4);
		cs_n = 1'b0;
		host_read(exp);
		cs_n = 1'b1;
	endtask
	task automatic t_reset();
		check("busy_n", busy_n, 1'b1);
		check("oe", sclk_oe, 1'b1);
		check("fsync", fsync, 1'b0);
		$display("done reset");
	endtask
	task automatic t_channel();
		for (int i = 0; i < 4; i++) begin
			addr = 2'(i);
			step(6);
			check("chan", chan, 16'(i));
		end
		str_b_n = 1'b1;
		addr = 2'h0;
		step(6);
		check("chan held", chan, 16'h0003);
		str_b_n = 1'b0;
		str_a_n = 1'b1;
		addr = 2'h1;
		step(6);
		check("chan held a", chan, 16'h0003);
		str_a_n = 1'b0;
		step(6);
		check("chan open", chan, 16'h0001);
		$display("done channel");
	endtask
	task automatic t_internal();
		int_cnt = 0;
		convert(16'hA5C3);
		finish_conv();
		check("int word", int_word, 16'h0000);
		check("int count", 16'(int_cnt), 16'h0010);
		int_cnt = 0;
		convert(16'h1234);
		finish_conv();
		step(20);
		check("int word", int_word, 16'hA5C3);
		check("int count", 16'(int_cnt), 16'h0010);
		$display("done internal");
	endtask
	task automatic t_external();
		ext_sel = 1'b1;
		step(6);
		check("oe", sclk_oe, 1'b0);
		convert(16'h5AF0);
		finish_conv();
		read_after(16'h5AF0);
		convert(16'h0F0F);
		rd_conv = 1'b1;
		host_read(16'h5AF0);
		cs_n = 1'b1;
		wait_busy(1'b1);
		read_after(16'h0F0F);
		$display("done external");
	endtask
	task automatic t_power();
		pd = 1'b1;
		step(8);
		check("power_save", psave, 1'b1);
		adc = 16'hFFFF;
		rd_conv = 1'b0;
		step(4);
		cs_n = 1'b0;
		step(50);
		check("busy_n pd", busy_n, 1'b1);
		cs_n = 1'b1;
		rd_conv = 1'b1;
		pd = 1'b0;
		step(8);
		check("power_save off", psave, 1'b0);
		read_after(16'h0F0F);
		$display("done power");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#500000;
		fail_count++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1;
		reset_n = 1'b1;
		step(4);
		t_reset();
		t_channel();
		t_internal();
		t_external();
		t_power();
		summarize();
	end
endmodule
